/* core/irq_defines.svh */
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// register word addresses (plain port)
`define ADDR_REQ0      8'h00
`define ADDR_REQ1      8'h01
`define ADDR_REQ2      8'h02
`define ADDR_EN0       8'h03
`define ADDR_EN1       8'h04
`define ADDR_EN2       8'h05
`define ADDR_LVLH0     8'h06
`define ADDR_LVLL0     8'h07
`define ADDR_LVLH1     8'h08
`define ADDR_LVLL1     8'h09
`define ADDR_LVLH2     8'h0A
`define ADDR_LVLL2     8'h0B
`define ADDR_CTRL      8'h0C
`define ADDR_PSEL      8'h0D
`define ADDR_EDGE      8'h0E
`define ADDR_VEC       8'h0F

// control register fields
`define CTRL_GIE_BIT   7
`define CTRL_RESET     8'h00
`define REG_RESET      8'h00

// vector addresses
`define VEC_RESET      16'h0002
`define VEC_WDT        16'h0004
`define VEC_ILLEGAL    16'h0006
`define VEC_FIRST      16'h0008
`define VEC_STEP       16'h0002

`define NUM_SRC        24
`define NUM_PERIPH     12
`define NUM_GPIO       12

`endif

/* core/irq_pkg.sv */
package irq_pkg;

   typedef enum logic [1:0] {
      lvl_off,
      lvl_one,
      lvl_two,
      lvl_three
   } prio_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] vector;
   } vec_offer_t;

   typedef struct packed {
      logic        enable_irq;
      logic        disable_irq;
      logic        return_irq;
      logic        trap;
      logic        illegal;
      logic        ack;
   } core_cmd_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage

/* core/gpio_edge_detect.sv */
`timescale 1ns/1ps
module gpio_edge_detect #(
   parameter int N = 8
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [N-1:0] pin,
   input  wire logic [N-1:0] fall_sel,
   input  wire logic         dual,
   output logic      [N-1:0] pulse
);
   logic [N-1:0] s1_r, s2_r, prev_r;
   logic [N-1:0] s1_nxt, s2_nxt, prev_nxt;
   logic [2:0]   vld_r, vld_nxt;

   // two-stage sync, then edge compare on stage two only
   always_comb begin
      s1_nxt   = ce ? pin : s1_r;
      s2_nxt   = ce ? s1_r : s2_r;
      prev_nxt = ce ? s2_r : prev_r;
      vld_nxt  = ce ? {vld_r[1:0], 1'b1} : vld_r;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r   <= '0;
         s2_r   <= '0;
         prev_r <= '0;
         vld_r  <= 3'h0;
      end else begin
         s1_r   <= s1_nxt;
         s2_r   <= s2_nxt;
         prev_r <= prev_nxt;
         vld_r  <= vld_nxt;
      end
   end

   // no edges until the pipe holds real pin samples after reset
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (!vld_r[2])
            pulse[i] = 1'b0;
         else if (dual)
            pulse[i] = ce & (s2_r[i] ^ prev_r[i]);
         else if (fall_sel[i])
            pulse[i] = ce & prev_r[i] & ~s2_r[i];
         else
            pulse[i] = ce & s2_r[i] & ~prev_r[i];
      end
   end
endmodule

/* core/prio_select.sv */
`timescale 1ns/1ps
module prio_select
   import irq_pkg::*;
#(
   parameter int N = 24
) (
   input  wire logic [N-1:0]   active,
   input  wire logic [2*N-1:0] level,
   output logic                found,
   output logic [4:0]          index
);
   // lowest index = highest default order; higher level first
   always_comb begin
      found = 1'b0;
      index = 5'd0;
      for (int l = 3; l >= 1; l--) begin
         for (int i = 0; i < N; i++) begin
            if (!found && active[i] && (level[2*i +: 2] == 2'(l))) begin
               found = 1'b1;
               index = 5'(i);
            end
         end
      end
   end
endmodule

/* core/vectored_priority_interrupt_ctrl.sv */
// Behaviour
// - 24 vectors: 12 GPIO, 12 peripheral
// - eight selectable-edge, four dual-edge GPIO sources
// - vector high byte even, low byte odd
// - peripherals timer2..ADC at 0008H-0016H
// - shared pins 7..0 at 0018H-0026H
// - timer3, UART1 rx/tx, DMA at 0028H-002EH
// - dual-edge pins 3..0 at 0030H-0036H
// - reset, watchdog, illegal trap outrank all
// - three levels, higher level always wins
// - same level: fixed default vector order
// - enable set by EI, RETURN_FROM_IRQ_INSTRUCTION, write 1
// - enable cleared by DI, ack, 0, traps
// - enable clear: only reset, watchdog, illegal vectors forwarded
// - one-cycle source pulses are latched
// - ack clears matching request bit
// - software write 0 clears request
// - software write 1 creates request
// - source pulse sets its request bit
// - enable set: forward pending enabled request whose level is not lvl_off
// - port select picks one group per pin
`timescale 1ns/1ps
`include "irq_defines.svh"
module vectored_priority_interrupt_ctrl
   import irq_pkg::*;
#(
   parameter bit HAS_TIMER3 = 1'b1
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [7:0]  periph_pulse,
   input  wire logic [3:0]  periph2_pulse,
   input  wire logic [7:0]  pin_group_a,
   input  wire logic [7:0]  pin_group_d,
   input  wire logic [3:0]  pin_group_c,
   input  wire logic        wdt_irq,
   input  wire logic        illegal_trap,
   input  wire logic        reset_vec_req,
   input  wire logic        enable_irq_instruction,
   input  wire logic        disable_irq_instruction,
   input  wire logic        return_from_irq_instruction,
   input  wire logic        trap_instruction,
   input  wire logic        irq_ack,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic             irq_req,
   output logic      [15:0] irq_vector,
   output logic             global_irq_enable_bit
);
   localparam int NS = `NUM_SRC;

   logic       rst_s1_r, rst_n;
   logic [NS-1:0] req_r, req_nxt;
   logic [NS-1:0] en_r, en_nxt;
   logic [2*NS-1:0] lvl_r, lvl_nxt;
   logic [7:0] psel_r, psel_nxt;
   logic [7:0] edge_r, edge_nxt;
   logic       gie_r, gie_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       irq_r, irq_nxt;
   logic [15:0] vec_r, vec_nxt;
   logic       wdt_s1_r, wdt_s2_r, ill_s1_r, ill_s2_r;
   logic [4:0] win_idx, ack_idx_r, ack_idx_nxt;
   logic       win_found;
   logic [7:0] pulse_a, pulse_d, pulse_c_raw;
   logic [NS-1:0] src_pulse;
   vec_offer_t offer;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // synchronise the watchdog and illegal-trap event pins; reset request used as is
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_s1_r <= 1'b0;
         wdt_s2_r <= 1'b0;
         ill_s1_r <= 1'b0;
         ill_s2_r <= 1'b0;
      end else if (ce) begin
         wdt_s1_r <= wdt_irq;
         wdt_s2_r <= wdt_s1_r;
         ill_s1_r <= illegal_trap;
         ill_s2_r <= ill_s1_r;
      end
   end

   gpio_edge_detect #(.N(8)) u_edge_a (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .pin      (pin_group_a),
      .fall_sel (edge_r),
      .dual     (1'b0),
      .pulse    (pulse_a)
   );

   gpio_edge_detect #(.N(8)) u_edge_d (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .pin      (pin_group_d),
      .fall_sel (edge_r),
      .dual     (1'b0),
      .pulse    (pulse_d)
   );

   gpio_edge_detect #(.N(8)) u_edge_c (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .pin      ({4'h0, pin_group_c}),
      .fall_sel (8'h00),
      .dual     (1'b1),
      .pulse    (pulse_c_raw)
   );

   // index 0 = highest default order; vector = 0008H + 2*index
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         src_pulse[i] = periph_pulse[7-i];
         src_pulse[8+i] = psel_r[7-i] ? pulse_d[7-i] : pulse_a[7-i];
      end
      src_pulse[16] = periph2_pulse[3] & HAS_TIMER3;
      src_pulse[17] = periph2_pulse[2];
      src_pulse[18] = periph2_pulse[1];
      src_pulse[19] = periph2_pulse[0];
      for (int i = 0; i < 4; i++) begin
         src_pulse[20+i] = pulse_c_raw[3-i];
      end
   end

   prio_select #(.N(NS)) u_prio (
      .active (req_r & en_r),
      .level  (lvl_r),
      .found  (win_found),
      .index  (win_idx)
   );

   function automatic logic [15:0] vec_of(input logic [4:0] idx);
      vec_of = `VEC_FIRST + 16'({idx, 1'b0});
   endfunction

   // byte view of a 24-bit vector register
   function automatic logic [7:0] byte_of(input logic [NS-1:0] v, input int b);
      byte_of = v[8*b +: 8];
   endfunction

   // request register bit order matches the status layout: bit7 = first
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = v[7-i];
      end
   endfunction

   always_comb begin
      offer.valid  = 1'b0;
      offer.vector = 16'h0000;
      if (reset_vec_req) begin
         offer.valid  = 1'b1;
         offer.vector = `VEC_RESET;
      end else if (wdt_s2_r) begin
         offer.valid  = 1'b1;
         offer.vector = `VEC_WDT;
      end else if (ill_s2_r) begin
         offer.valid  = 1'b1;
         offer.vector = `VEC_ILLEGAL;
      end else if (gie_r && win_found) begin
         offer.valid  = 1'b1;
         offer.vector = vec_of(win_idx);
      end
   end

   always_comb begin
      req_nxt     = req_r;
      en_nxt      = en_r;
      lvl_nxt     = lvl_r;
      psel_nxt    = psel_r;
      edge_nxt    = edge_r;
      gie_nxt     = gie_r;
      rdata_nxt   = rdata_r;
      ack_idx_nxt = ack_idx_r;
      irq_nxt     = irq_r;
      vec_nxt     = vec_r;
      if (ce) begin
         rdata_nxt = 8'h00;
         irq_nxt = offer.valid;
         vec_nxt = offer.vector;
         if (offer.valid && gie_r && win_found)
            ack_idx_nxt = win_idx;
         if (irq_ack && irq_r && vec_r >= `VEC_FIRST)
            req_nxt[ack_idx_r] = 1'b0;
         if (reg_wr) begin
            case (reg_addr)
               `ADDR_REQ0: req_nxt[7:0]   = rev8(reg_wdata);
               `ADDR_REQ1: req_nxt[15:8]  = rev8(reg_wdata);
               `ADDR_REQ2: req_nxt[23:16] = rev8(reg_wdata);
               `ADDR_EN0:  en_nxt[7:0]    = rev8(reg_wdata);
               `ADDR_EN1:  en_nxt[15:8]   = rev8(reg_wdata);
               `ADDR_EN2:  en_nxt[23:16]  = rev8(reg_wdata);
               `ADDR_LVLH0: lvl_nxt[15:0]  = {lvl_r[15:8], rev8(reg_wdata)};
               `ADDR_LVLL0: lvl_nxt[15:0]  = {rev8(reg_wdata), lvl_r[7:0]};
               `ADDR_LVLH1: lvl_nxt[31:16] = {lvl_r[31:24], rev8(reg_wdata)};
               `ADDR_LVLL1: lvl_nxt[31:16] = {rev8(reg_wdata), lvl_r[23:16]};
               `ADDR_LVLH2: lvl_nxt[47:32] = {lvl_r[47:40], rev8(reg_wdata)};
               `ADDR_LVLL2: lvl_nxt[47:32] = {rev8(reg_wdata), lvl_r[39:32]};
               `ADDR_CTRL: gie_nxt = reg_wdata[`CTRL_GIE_BIT];
               `ADDR_PSEL: psel_nxt = reg_wdata;
               `ADDR_EDGE: edge_nxt = reg_wdata;
               default: ;
            endcase
         end
         if (enable_irq_instruction || return_from_irq_instruction)
            gie_nxt = 1'b1;
         if (disable_irq_instruction || irq_ack || trap_instruction || ill_s2_r)
            gie_nxt = 1'b0;
         req_nxt = req_nxt | src_pulse;
         if (reg_rd) begin
            case (reg_addr)
               `ADDR_REQ0: rdata_nxt = rev8(byte_of(req_r, 0));
               `ADDR_REQ1: rdata_nxt = rev8(byte_of(req_r, 1));
               `ADDR_REQ2: rdata_nxt = rev8(byte_of(req_r, 2));
               `ADDR_EN0:  rdata_nxt = rev8(byte_of(en_r, 0));
               `ADDR_EN1:  rdata_nxt = rev8(byte_of(en_r, 1));
               `ADDR_EN2:  rdata_nxt = rev8(byte_of(en_r, 2));
               `ADDR_LVLH0: rdata_nxt = rev8(lvl_r[7:0]);
               `ADDR_LVLL0: rdata_nxt = rev8(lvl_r[15:8]);
               `ADDR_LVLH1: rdata_nxt = rev8(lvl_r[23:16]);
               `ADDR_LVLL1: rdata_nxt = rev8(lvl_r[31:24]);
               `ADDR_LVLH2: rdata_nxt = rev8(lvl_r[39:32]);
               `ADDR_LVLL2: rdata_nxt = rev8(lvl_r[47:40]);
               `ADDR_CTRL: rdata_nxt = {gie_r, 7'h00};
               `ADDR_PSEL: rdata_nxt = psel_r;
               `ADDR_EDGE: rdata_nxt = edge_r;
               `ADDR_VEC:  rdata_nxt = vec_r[7:0];
               default:    rdata_nxt = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_r     <= '0;
         en_r      <= '0;
         lvl_r     <= '0;
         psel_r    <= `REG_RESET;
         edge_r    <= `REG_RESET;
         gie_r     <= 1'b0;
         rdata_r   <= 8'h00;
         ack_idx_r <= 5'd0;
         irq_r     <= 1'b0;
         vec_r     <= 16'h0000;
      end else begin
         req_r     <= req_nxt;
         en_r      <= en_nxt;
         lvl_r     <= lvl_nxt;
         psel_r    <= psel_nxt;
         edge_r    <= edge_nxt;
         gie_r     <= gie_nxt;
         rdata_r   <= rdata_nxt;
         ack_idx_r <= ack_idx_nxt;
         irq_r     <= irq_nxt;
         vec_r     <= vec_nxt;
      end
   end

   assign reg_rdata             = rdata_r;
   assign irq_req               = irq_r;
   assign irq_vector            = vec_r;
   assign global_irq_enable_bit = gie_r;
endmodule

/* bench/irq_ctrl_chk.sv */
`timescale 1ns/1ps
`include "irq_defines.svh"
module irq_ctrl_chk (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        ce,
   input wire logic        enable_irq_instruction,
   input wire logic        return_from_irq_instruction,
   input wire logic        disable_irq_instruction,
   input wire logic        trap_instruction,
   input wire logic        irq_ack,
   input wire logic        reset_vec_req,
   input wire logic        wdt_irq,
   input wire logic        illegal_trap,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        irq_req,
   input wire logic [15:0] irq_vector,
   input wire logic        global_irq_enable_bit
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic set_c;
   logic clr_c;
   logic hi;
   logic gie;
   assign set_c = ce & (enable_irq_instruction | return_from_irq_instruction);
   assign clr_c = ce & (disable_irq_instruction | trap_instruction | irq_ack);
   assign hi    = reset_vec_req | wdt_irq | illegal_trap;
   assign gie   = global_irq_enable_bit;
   a_ei_sets: assert property (set_c && !clr_c && !reg_wr |=> gie)
      else $error("enable not set");
   a_di_clears: assert property (clr_c && !set_c && !reg_wr |=> !gie)
      else $error("enable not cleared");
   a_wr_enable: assert property (ce && reg_wr && reg_addr == `ADDR_CTRL && !set_c && !clr_c
      |=> gie == $past(reg_wdata[`CTRL_GIE_BIT]))
      else $error("enable ignores write");
   a_polled_quiet: assert property (irq_req && !gie && !$past(gie)
      |-> irq_vector inside {`VEC_RESET, `VEC_WDT, `VEC_ILLEGAL})
      else $error("vector while disabled");
   a_vec_range: assert property (irq_req |-> !irq_vector[0] && irq_vector >= `VEC_RESET
      && irq_vector <= 16'h0036)
      else $error("vector outside table");
   a_rd_answer: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data out of slot");
   a_ack_drops: assert property (ce && irq_ack && irq_req && irq_vector >= `VEC_FIRST
      && !set_c && !reg_wr && !hi ##1 ce && !set_c && !reg_wr && !hi |=> !irq_req)
      else $error("offer stands after ack");
   a_fixed_top: assert property (reset_vec_req && $past(reset_vec_req)
      |-> irq_req && irq_vector == `VEC_RESET)
      else $error("reset vector not first");
endmodule

bind vectored_priority_interrupt_ctrl irq_ctrl_chk chk (.*);

/* bench/core_model.sv */
`timescale 1ns/1ps
module core_model
   import irq_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   output core_cmd_t        cmd
);
   logic        auto_ack = 1'b0;
   int          delay    = 0;
   int          acks     = 0;
   logic [15:0] last_vec = 16'h0000;
   initial cmd = '0;
   task automatic issue(input core_cmd_t c, input int n);
      @(posedge ref_clk);
      cmd <= c;
      repeat (n) @(posedge ref_clk);
      cmd <= '0;
   endtask
   // ack an offer once seen on irq_req, optionally late, without checking that it still stands
   always begin
      @(posedge ref_clk);
      if (auto_ack && irq_req) begin
         repeat (delay) @(posedge ref_clk);
         last_vec = irq_vector;
         cmd.ack <= 1'b1;
         @(posedge ref_clk);
         cmd.ack <= 1'b0;
         acks++;
         repeat (2) @(posedge ref_clk);
      end
   end
endmodule

/* bench/vectored_priority_interrupt_ctrl_tb.sv */
`timescale 1ns/1ps
`include "irq_defines.svh"
module vectored_priority_interrupt_ctrl_tb
   import irq_pkg::*;
;
   typedef struct {
      int          grp;
      int          pos;
      logic [15:0] vec;
   } row_t;
   logic        ref_clk   = 1'b0;
   logic        nrst      = 1'b0;
   logic        rd        = 1'b0;
   logic        wr        = 1'b0;
   logic        rsv       = 1'b0;
   logic        wdt       = 1'b0;
   logic [7:0]  pp        = 8'h00;
   logic [7:0]  pa        = 8'h00;
   logic [7:0]  pd        = 8'h00;
   logic [3:0]  p2        = 4'h0;
   logic [3:0]  pc        = 4'h0;
   logic [7:0]  addr      = 8'h00;
   logic [7:0]  wd        = 8'h00;
   logic [5:0]  ops[4]    = '{6'h08, 6'h10, 6'h20, 6'h04};
   logic [7:0]  rdata;
   logic        req;
   logic        gie;
   logic [15:0] vec;
   core_cmd_t   cmd;
   row_t        rows[24];
   int          bad_count = 0;
   int          tests_run = 0;
   always #10 ref_clk = ~ref_clk;
   vectored_priority_interrupt_ctrl dut (
      .ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .periph_pulse(pp), .periph2_pulse(p2),
      .pin_group_a(pa), .pin_group_d(pd), .pin_group_c(pc), .wdt_irq(wdt),
      .illegal_trap(cmd.illegal), .reset_vec_req(rsv), .enable_irq_instruction(cmd.enable_irq),
      .disable_irq_instruction(cmd.disable_irq), .return_from_irq_instruction(cmd.return_irq),
      .trap_instruction(cmd.trap), .irq_ack(cmd.ack), .reg_addr(addr), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq_req(req), .irq_vector(vec),
      .global_irq_enable_bit(gie));
   core_model core (.ref_clk(ref_clk), .irq_req(req), .irq_vector(vec), .cmd(cmd));
   task automatic check(input string what, input logic [15:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge ref_clk);
      addr <= a;
      wd   <= d;
      wr   <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] a, exp, input string what);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(posedge ref_clk);
      check(what, {8'h00, exp}, {8'h00, rdata});
   endtask
   task automatic fire(input int g, b);
      @(posedge ref_clk);
      case (g)
         0: pp[b] <= 1'b1;
         1: pa[b] <= ~pa[b];
         2: p2[b] <= 1'b1;
         default: pc[b] <= ~pc[b];
      endcase
      @(posedge ref_clk);
      pp <= 8'h00;
      p2 <= 4'h0;
   endtask
   task automatic wait_ack(input int n0);
      for (int i = 0; i < 40 && core.acks == n0; i++) @(posedge ref_clk);
   endtask
   // timer2 and adc pending together under given levels
   task automatic lvl_run(input logic [7:0] h, l, output logic [15:0] v);
      int n0;
      core.auto_ack = 1'b0;
      wr_reg(`ADDR_CTRL, 8'h00);
      wr_reg(`ADDR_REQ0, 8'h00);
      wr_reg(`ADDR_LVLH0, h);
      wr_reg(`ADDR_LVLL0, l);
      fire(0, 7);
      fire(0, 0);
      core.auto_ack = 1'b1;
      n0 = core.acks;
      wr_reg(`ADDR_CTRL, 8'h80);
      wait_ack(n0);
      v = core.last_vec;
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge ref_clk);
      bad_count++;
      $display("watchdog expired");
      results();
   end
   initial begin
      logic [15:0] va;
      logic [15:0] vb;
      int          n;
      for (n = 0; n < 24; n++) begin
         rows[n].grp = n < 8 ? 0 : n < 16 ? 1 : n < 20 ? 2 : 3;
         rows[n].pos = n < 8 ? 7 - n : n < 16 ? 15 - n : n < 20 ? 19 - n : 23 - n;
         rows[n].vec = `VEC_FIRST + 16'(2 * n);
      end
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk_reg(`ADDR_CTRL, `CTRL_RESET, "ctrl at reset");
      for (n = 0; n < 9; n++) wr_reg(`ADDR_EN0 + 8'(n), 8'hFF);
      core.auto_ack = 1'b1;
      wr_reg(`ADDR_CTRL, 8'h80);
      foreach (rows[i]) begin
         n = core.acks;
         fire(rows[i].grp, rows[i].pos);
         wait_ack(n);
         check("vector", rows[i].vec, core.last_vec);
         chk_reg(8'(i / 8), 8'h00, "acked bit");
         wr_reg(`ADDR_CTRL, 8'h80);
      end
      $display("done: source table");
      core.auto_ack = 1'b0;
      wr_reg(`ADDR_CTRL, 8'h00);
      wr_reg(`ADDR_REQ0, 8'h81);
      repeat (4) @(posedge ref_clk);
      check("polled offer", 16'h0000, {15'h0000, req});
      chk_reg(`ADDR_REQ0, 8'h81, "polled bits");
      wr_reg(`ADDR_REQ0, 8'h01);
      chk_reg(`ADDR_REQ0, 8'h01, "soft clear");
      core.auto_ack = 1'b1;
      n = core.acks;
      core.issue(core_cmd_t'(6'h20), 1);
      wait_ack(n);
      check("soft request", 16'h0016, core.last_vec);
      chk_reg(`ADDR_REQ0, 8'h00, "soft acked");
      $display("done: polled and software requests");
      core.delay = 3;
      lvl_run(8'hFF, 8'hFF, va);
      check("same level", `VEC_FIRST, va);
      lvl_run(8'h55, 8'hFF, va);
      lvl_run(8'hFF, 8'h55, vb);
      check("level pair", 16'h001E, va + vb);
      check("level swap", 16'h0001, {15'h0000, va != vb});
      $display("done: levels");
      core.auto_ack = 1'b0;
      wr_reg(`ADDR_CTRL, 8'h80);
      @(posedge ref_clk);
      rsv <= 1'b1;
      wdt <= 1'b1;
      repeat (5) @(posedge ref_clk);
      check("reset vector", `VEC_RESET, vec);
      rsv <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check("watchdog vector", `VEC_WDT, vec);
      wdt <= 1'b0;
      repeat (4) @(posedge ref_clk);
      core.issue(core_cmd_t'(6'h02), 8);
      check("illegal vector", `VEC_ILLEGAL, vec);
      chk_reg(`ADDR_CTRL, 8'h00, "illegal clears");
      for (n = 0; n < 4; n++) begin
         core.issue(core_cmd_t'(ops[n]), 1);
         @(posedge ref_clk);
         check("enable", {15'h0000, ops[n][5] | ops[n][3]}, {15'h0000, gie});
      end
      $display("done: fixed vectors and instructions");
      wr_reg(`ADDR_EDGE, 8'h40);
      fire(1, 6);
      repeat (4) @(posedge ref_clk);
      chk_reg(`ADDR_REQ1, 8'h40, "falling edge");
      wr_reg(`ADDR_REQ1, 8'h00);
      fire(1, 7);
      wr_reg(`ADDR_PSEL, 8'h80);
      fire(1, 7);
      repeat (6) @(posedge ref_clk);
      chk_reg(`ADDR_REQ1, 8'h00, "deselected pin");
      pd[7] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk_reg(`ADDR_REQ1, 8'h80, "selected pin");
      chk_reg(8'h20, 8'h00, "unmapped");
      $display("done: port select");
      nrst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk_reg(`ADDR_REQ1, `REG_RESET, "req after reset");
      chk_reg(`ADDR_CTRL, `CTRL_RESET, "ctrl after reset");
      $display("done: mid-run reset");
      results();
   end
endmodule
